// >>> include/psr_pkg.sv
package psr_pkg;

  // command codes of the status bank
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUM_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT = 8'h7a;
  localparam logic [7:0] CMD_IOUT = 8'h7b;
  localparam logic [7:0] CMD_INPUT = 8'h7c;
  localparam logic [7:0] CMD_TEMP = 8'h7d;
  localparam logic [7:0] CMD_CML = 8'h7e;
  localparam logic [7:0] CMD_VENDOR = 8'h80;
  localparam logic [7:0] CMD_PADS = 8'he5;

  // summary byte bit positions
  localparam int SUM_BUSY = 7;
  localparam int SUM_OFF = 6;
  localparam int SUM_OV = 5;
  localparam int SUM_OC = 4;
  localparam int SUM_TEMP = 2;
  localparam int SUM_CML = 1;
  localparam int SUM_OTHER = 0;
  // summary word high bit positions
  localparam int WRD_VOUT = 15;
  localparam int WRD_IOUT = 14;
  localparam int WRD_INPUT = 13;
  localparam int WRD_VENDOR = 12;
  localparam int WRD_PGOOD_N = 11;
  // detail bit positions
  localparam int OUTPUT_OVERVOLTAGE_FLAG_FAULT = 7;
  localparam int OUTPUT_OVERCURRENT_FLAG_FAULT = 7;
  localparam int INP_OV_FAULT = 7;
  localparam int CML_INV_CMD = 7;
  localparam int CML_INV_DATA = 6;

  // supported bits of each register, and the write-one-clear bits of the summary byte and input register
  localparam logic [7:0] SUM_W1C_MASK = 8'h81;
  localparam logic [7:0] VOUT_MASK = 8'hfe;
  localparam logic [7:0] IOUT_MASK = 8'ha0;
  localparam logic [7:0] INP_MASK = 8'ha8;
  localparam logic [7:0] INP_W1C_MASK = 8'h80;
  localparam logic [7:0] TEMP_MASK = 8'hd0;
  localparam logic [7:0] CML_MASK = 8'hfb;
  localparam logic [7:0] VENDOR_MASK = 8'hfb;
  localparam logic [15:0] PAD_MASK = 16'hcfff;

  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic RST_PAGE = 1'b0;

  // link clock half period in ref_clk cycles
  localparam logic [2:0] LINK_HALF_CYC = 3'h4;

  // raw fault levels and pin states entering the device
  typedef struct packed {
    logic [1:0][7:0] vout;
    logic [1:0][7:0] iout;
    logic [1:0][7:0] temp;
    logic [1:0][7:0] vendor;
    logic [1:0] busy;
    logic [1:0] other;
    logic [1:0] outOn;
    logic [1:0] pwrGood;
    logic [7:0] inp;
    logic [7:0] comm_memory_logic_flag;
    logic [15:0] pads;
  } psr_raw_t;

endpackage : psr_pkg

// >>> include/psr_link_if.sv
`timescale 1ns/10ps
interface psr_link_if;
  logic linkClk;
  logic cmdValid;
  logic cmdWrite;
  logic [7:0] cmdCode;
  logic [15:0] cmdData;
  logic rspValid;
  logic [15:0] rspData;

  modport host (
    output linkClk,
    output cmdValid,
    output cmdWrite,
    output cmdCode,
    output cmdData,
    input rspValid,
    input rspData
  );

  modport dev (
    input linkClk,
    input cmdValid,
    input cmdWrite,
    input cmdCode,
    input cmdData,
    output rspValid,
    output rspData
  );
endinterface : psr_link_if

// >>> design/psr_status_dev.sv
`timescale 1ns/10ps
module psr_status_dev (
  input wire logic rst,
  psr_link_if.dev link,
  input wire psr_pkg::psr_raw_t rawIn,
  output logic alert
);

  typedef struct packed {
    psr_pkg::psr_raw_t meta;
    psr_pkg::psr_raw_t sync;
    logic page;
    logic [1:0][7:0] vout;
    logic [1:0][7:0] iout;
    logic [1:0][7:0] temp;
    logic [1:0][7:0] vendor;
    logic [1:0] busy;
    logic [1:0] other;
    logic [7:0] inp;
    logic [7:0] comm_memory_logic_flag;
    logic rspValid;
    logic [15:0] rspData;
    logic alert;
  } psr_dev_t;

  psr_dev_t q;
  psr_dev_t d;

  // write-one-clear mask for one register, or all ones on clear-all
  function automatic logic [7:0] clrMask(
    input logic hit,
    input logic all,
    input logic [7:0] data
  );
    if (all) begin
      clrMask = 8'hff;
    end else if (hit) begin
      clrMask = data;
    end else begin
      clrMask = 8'h00;
    end
  endfunction : clrMask

  // summary byte of one channel
  function automatic logic [7:0] sumByte(
    input psr_dev_t s,
    input logic ch
  );
    sumByte = 8'h00;
    sumByte[psr_pkg::SUM_BUSY] = s.busy[ch];
    sumByte[psr_pkg::SUM_OFF] = ~s.sync.outOn[ch];
    sumByte[psr_pkg::SUM_OV] = s.vout[ch][psr_pkg::OUTPUT_OVERVOLTAGE_FLAG_FAULT];
    sumByte[psr_pkg::SUM_OC] = s.iout[ch][psr_pkg::OUTPUT_OVERCURRENT_FLAG_FAULT];
    sumByte[psr_pkg::SUM_TEMP] = |s.temp[ch];
    sumByte[psr_pkg::SUM_CML] = |s.comm_memory_logic_flag;
    sumByte[psr_pkg::SUM_OTHER] = s.other[ch];
  endfunction : sumByte

  // summary word of one channel
  function automatic logic [15:0] sumWord(
    input psr_dev_t s,
    input logic ch
  );
    sumWord = {8'h00, sumByte(s, ch)};
    sumWord[psr_pkg::WRD_VOUT] = |s.vout[ch];
    sumWord[psr_pkg::WRD_IOUT] = |s.iout[ch];
    sumWord[psr_pkg::WRD_INPUT] = |s.inp;
    sumWord[psr_pkg::WRD_VENDOR] = |s.vendor[ch];
    sumWord[psr_pkg::WRD_PGOOD_N] = ~s.sync.pwrGood[ch];
  endfunction : sumWord

  logic serve;
  logic wr;
  logic clrAll;
  logic [7:0] wrByte;
  logic known;

  // request decode: one service per handshake
  always_comb begin
    serve = link.cmdValid & ~q.rspValid;
    wr = serve & link.cmdWrite;
    clrAll = wr & (link.cmdCode == psr_pkg::CMD_CLEAR);
    wrByte = link.cmdData[7:0];
    case (link.cmdCode)
      psr_pkg::CMD_PAGE,
      psr_pkg::CMD_CLEAR,
      psr_pkg::CMD_SUM_BYTE,
      psr_pkg::CMD_SUM_WORD,
      psr_pkg::CMD_VOUT,
      psr_pkg::CMD_IOUT,
      psr_pkg::CMD_INPUT,
      psr_pkg::CMD_TEMP,
      psr_pkg::CMD_CML,
      psr_pkg::CMD_VENDOR,
      psr_pkg::CMD_PADS: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // next state: clears first, then live events set, so set wins
  always_comb begin
    d = q;
    d.meta = rawIn;
    d.sync = q.meta;
    if (wr & (link.cmdCode == psr_pkg::CMD_PAGE)) begin
      d.page = link.cmdData[0];
    end
    for (int ch = 0; ch < 2; ch++) begin
      // only the channel chosen by the page sees single writes
      if (q.page == ch[0]) begin
        d.busy[ch] = q.busy[ch]
          & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_SUM_BYTE), clrAll,
                     wrByte & psr_pkg::SUM_W1C_MASK)[psr_pkg::SUM_BUSY];
        d.other[ch] = q.other[ch]
          & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_SUM_BYTE), clrAll,
                     wrByte & psr_pkg::SUM_W1C_MASK)[psr_pkg::SUM_OTHER];
        d.vout[ch] = q.vout[ch]
          & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_VOUT), clrAll, wrByte);
        d.iout[ch] = q.iout[ch]
          & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_IOUT), clrAll, wrByte);
        d.temp[ch] = q.temp[ch]
          & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_TEMP), clrAll, wrByte);
        d.vendor[ch] = q.vendor[ch]
          & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_VENDOR), clrAll,
                     wrByte);
      end else if (clrAll) begin
        d.busy[ch] = 1'b0;
        d.other[ch] = 1'b0;
        d.vout[ch] = psr_pkg::RST_STATUS;
        d.iout[ch] = psr_pkg::RST_STATUS;
        d.temp[ch] = psr_pkg::RST_STATUS;
        d.vendor[ch] = psr_pkg::RST_STATUS;
      end
      // live faults set their sticky bits, masked to supported ones
      d.busy[ch] = d.busy[ch] | q.sync.busy[ch];
      d.other[ch] = d.other[ch] | q.sync.other[ch];
      d.vout[ch] = d.vout[ch] | (q.sync.vout[ch] & psr_pkg::VOUT_MASK);
      d.iout[ch] = d.iout[ch] | (q.sync.iout[ch] & psr_pkg::IOUT_MASK);
      d.temp[ch] = d.temp[ch] | (q.sync.temp[ch] & psr_pkg::TEMP_MASK);
      d.vendor[ch] = d.vendor[ch] | (q.sync.vendor[ch] & psr_pkg::VENDOR_MASK);
    end
    // shared input register: only the overvoltage bit clears singly
    d.inp = q.inp & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_INPUT), clrAll,
                             clrAll ? 8'hff : (wrByte & psr_pkg::INP_W1C_MASK));
    d.inp = d.inp | (q.sync.inp & psr_pkg::INP_MASK);
    // shared cml register
    d.comm_memory_logic_flag = q.comm_memory_logic_flag & ~clrMask(wr & (link.cmdCode == psr_pkg::CMD_CML), clrAll,
                             wrByte);
    d.comm_memory_logic_flag = d.comm_memory_logic_flag | (q.sync.comm_memory_logic_flag & psr_pkg::CML_MASK);
    // bad commands and writes to the read-only pad word
    if (serve & ~known) begin
      d.comm_memory_logic_flag[psr_pkg::CML_INV_CMD] = 1'b1;
    end
    if (wr & (link.cmdCode == psr_pkg::CMD_PADS)) begin
      d.comm_memory_logic_flag[psr_pkg::CML_INV_DATA] = 1'b1;
    end
    // answer once per request, hold until the request drops
    if (serve) begin
      d.rspValid = 1'b1;
      case (link.cmdCode)
        psr_pkg::CMD_PAGE: d.rspData = {15'h0000, q.page};
        psr_pkg::CMD_SUM_BYTE: d.rspData = {8'h00, sumByte(q, q.page)};
        psr_pkg::CMD_SUM_WORD: d.rspData = sumWord(q, q.page);
        psr_pkg::CMD_VOUT: d.rspData = {8'h00, q.vout[q.page]};
        psr_pkg::CMD_IOUT: d.rspData = {8'h00, q.iout[q.page]};
        psr_pkg::CMD_INPUT: d.rspData = {8'h00, q.inp};
        psr_pkg::CMD_TEMP: d.rspData = {8'h00, q.temp[q.page]};
        psr_pkg::CMD_CML: d.rspData = {8'h00, q.comm_memory_logic_flag};
        psr_pkg::CMD_VENDOR: d.rspData = {8'h00, q.vendor[q.page]};
        psr_pkg::CMD_PADS: d.rspData = q.sync.pads & psr_pkg::PAD_MASK;
        default: d.rspData = 16'h0000;
      endcase
    end else if (~link.cmdValid) begin
      d.rspValid = 1'b0;
    end
    // alert from every alert-capable sticky bit of either channel
    d.alert = |{d.busy, d.other, d.vout, d.iout, d.temp, d.vendor,
                d.inp[psr_pkg::INP_OV_FAULT], d.comm_memory_logic_flag};
  end

  // state register on the link clock
  always_ff @(posedge link.linkClk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.page <= psr_pkg::RST_PAGE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign link.rspValid = q.rspValid;
  assign link.rspData = q.rspData;
  assign alert = q.alert;

endmodule : psr_status_dev

// >>> design/psr_status_host.sv
`timescale 1ns/10ps
module psr_status_host (
  input wire logic ref_clk,
  input wire logic rst,
  psr_link_if.host link,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [7:0] reqCode,
  input wire logic [15:0] reqData,
  output logic reqReady,
  output logic doneValid,
  output logic [15:0] doneData
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOAD = 2'b01,
    H_ACK = 2'b10,
    H_REL = 2'b11
  } psr_hst_e;

  typedef struct packed {
    logic [2:0] div;
    logic clk;
    psr_hst_e st;
    logic rdy;
    logic wr;
    logic [7:0] code;
    logic [15:0] data;
    logic cv;
    logic metaV;
    logic syncV;
    logic doneV;
    logic [15:0] doneD;
  } psr_hst_t;

  psr_hst_t q;
  psr_hst_t d;
  logic fallEvt;

  always_comb begin
    d = q;
    // link clock divider; command changes with the falling edge
    fallEvt = q.clk & (q.div == psr_pkg::LINK_HALF_CYC - 3'h1);
    if (q.div == psr_pkg::LINK_HALF_CYC - 3'h1) begin
      d.div = 3'h0;
      d.clk = ~q.clk;
    end else begin
      d.div = q.div + 3'h1;
    end
    // answer flag crosses into ref_clk
    d.metaV = link.rspValid;
    d.syncV = q.metaV;
    d.doneV = 1'b0;
    case (q.st)
      H_IDLE: begin
        if (reqValid) begin
          d.wr = reqWrite; // writes of ones clear status
          d.code = reqCode;
          d.data = reqData;
          d.rdy = 1'b0;
          d.st = H_LOAD;
        end
      end
      H_LOAD: begin
        if (fallEvt) begin
          d.cv = 1'b1;
          d.st = H_ACK;
        end
      end
      H_ACK: begin
        if (q.syncV & fallEvt) begin
          d.cv = 1'b0;
          d.doneV = 1'b1;
          d.doneD = link.rspData;
          d.st = H_REL;
        end
      end
      H_REL: begin
        if (~q.syncV) begin
          d.rdy = 1'b1;
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= H_IDLE;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign link.linkClk = q.clk;
  assign link.cmdValid = q.cv;
  assign link.cmdWrite = q.wr;
  assign link.cmdCode = q.code;
  assign link.cmdData = q.data;
  assign reqReady = q.rdy;
  assign doneValid = q.doneV;
  assign doneData = q.doneD;

endmodule : psr_status_host

// >>> dv/psr_status_chk.sv
`timescale 1ns/10ps
// link watcher: reserved answer bits and the four-phase handshake
module psr_status_chk (
  input wire logic linkClk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdData,
  input wire logic rspValid,
  input wire logic [15:0] rspData
);
  logic rspQ;
  logic rd;
  default clocking @(posedge linkClk); endclocking
  default disable iff (rst);
  // last answer flag, marks the first edge of an answer
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) rspQ <= 1'b0;
    else rspQ <= rspValid;
  end
  assign rd = rspValid && !rspQ && !cmdWrite;
  a_byte_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_SUM_BYTE |-> rspData[15:8] == 8'h00 && rspData[3] == 1'b0)
    else $error("summary byte reserved bit set");
  a_word_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_SUM_WORD |-> rspData[10:8] == 3'h0 && rspData[3] == 1'b0)
    else $error("summary word reserved bit set");
  a_vout_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_VOUT |-> (rspData & 16'hff01) == 16'h0000)
    else $error("vout reserved bit set");
  a_iout_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_IOUT |-> (rspData & 16'hff5f) == 16'h0000)
    else $error("iout reserved bit set");
  a_input_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_INPUT |-> (rspData & 16'hff57) == 16'h0000)
    else $error("input reserved bit set");
  a_temp_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_TEMP |-> (rspData & 16'hff2f) == 16'h0000)
    else $error("temp reserved bit set");
  a_cml_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_CML |-> (rspData & 16'hff04) == 16'h0000)
    else $error("cml reserved bit set");
  a_vendor_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_VENDOR |-> (rspData & 16'hff04) == 16'h0000)
    else $error("vendor reserved bit set");
  a_pads_reserved: assert property (
    rd && cmdCode == psr_pkg::CMD_PADS |-> rspData[13:12] == 2'h0)
    else $error("pad word reserved bit set");
  a_answer_rise: assert property (!rspValid && cmdValid |=> rspValid)
    else $error("request not answered");
  a_answer_fall: assert property (rspValid && !cmdValid |=> !rspValid)
    else $error("answer not withdrawn");
endmodule : psr_status_chk

// >>> dv/pmbus_status_reporting_test.sv
`timescale 1ns/10ps
// host user side and raw device inputs driven, every read answer checked
module pmbus_status_reporting_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [7:0] reqCode = 8'h00;
  logic [15:0] reqData = 16'h0000;
  logic reqReady;
  logic doneValid;
  logic [15:0] doneData;
  logic alert;
  psr_pkg::psr_raw_t raw = '0;
  psr_pkg::psr_raw_t rawIn = '0;
  logic [7:0] m[4][2];
  logic [1:0] mb;
  logic [1:0] mo;
  logic [7:0] mn;
  logic [7:0] mc;
  logic pg = 1'b0;
  logic [15:0] r;
  logic [127:0] rnd;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] codes[9] = '{psr_pkg::CMD_SUM_BYTE, psr_pkg::CMD_SUM_WORD, psr_pkg::CMD_VOUT,
    psr_pkg::CMD_IOUT, psr_pkg::CMD_INPUT, psr_pkg::CMD_TEMP, psr_pkg::CMD_CML,
    psr_pkg::CMD_VENDOR, psr_pkg::CMD_PADS};
  logic [7:0] w1c[7] = '{psr_pkg::CMD_SUM_BYTE, psr_pkg::CMD_VOUT, psr_pkg::CMD_IOUT,
    psr_pkg::CMD_INPUT, psr_pkg::CMD_TEMP, psr_pkg::CMD_CML, psr_pkg::CMD_VENDOR};

  psr_link_if lnk ();
  psr_status_host psr_status_host_inst (.ref_clk(ref_clk), .rst(rst), .link(lnk),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqCode(reqCode), .reqData(reqData),
    .reqReady(reqReady), .doneValid(doneValid), .doneData(doneData));
  psr_status_dev psr_status_dev_inst (.rst(rst), .link(lnk), .rawIn(rawIn), .alert(alert));
  psr_status_chk psr_status_chk_inst (.linkClk(lnk.linkClk), .rst(rst),
    .cmdValid(lnk.cmdValid), .cmdWrite(lnk.cmdWrite), .cmdCode(lnk.cmdCode),
    .cmdData(lnk.cmdData), .rspValid(lnk.rspValid), .rspData(lnk.rspData));

  // free-running reference clock
  always #2.5 ref_clk = ~ref_clk;

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // model: clear every status bit, page kept
  task automatic zero;
    m = '{default: 8'h00};
    mb = 2'b00;
    mo = 2'b00;
    mn = 8'h00;
    mc = 8'h00;
  endtask : zero

  // model: live raw faults stick
  task automatic absorb;
    for (int c = 0; c < 2; c++) begin
      m[0][c] |= raw.vout[c] & psr_pkg::VOUT_MASK;
      m[1][c] |= raw.iout[c] & psr_pkg::IOUT_MASK;
      m[2][c] |= raw.temp[c] & psr_pkg::TEMP_MASK;
      m[3][c] |= raw.vendor[c] & psr_pkg::VENDOR_MASK;
      mb[c] |= raw.busy[c];
      mo[c] |= raw.other[c];
    end
    mn |= raw.inp & psr_pkg::INP_MASK;
    mc |= raw.comm_memory_logic_flag & psr_pkg::CML_MASK;
  endtask : absorb

  function automatic logic [15:0] ex(input logic [7:0] c, input logic ch);
    logic [7:0] sb;
    sb = {mb[ch], ~raw.outOn[ch], m[0][ch][7], m[1][ch][7], 1'b0, |m[2][ch], |mc, mo[ch]};
    case (c)
      psr_pkg::CMD_SUM_BYTE: ex = {8'h00, sb};
      psr_pkg::CMD_SUM_WORD: ex = {|m[0][ch], |m[1][ch], |mn, |m[3][ch], ~raw.pwrGood[ch],
        3'h0, sb};
      psr_pkg::CMD_VOUT: ex = {8'h00, m[0][ch]};
      psr_pkg::CMD_IOUT: ex = {8'h00, m[1][ch]};
      psr_pkg::CMD_TEMP: ex = {8'h00, m[2][ch]};
      psr_pkg::CMD_VENDOR: ex = {8'h00, m[3][ch]};
      psr_pkg::CMD_INPUT: ex = {8'h00, mn};
      psr_pkg::CMD_CML: ex = {8'h00, mc};
      psr_pkg::CMD_PADS: ex = raw.pads & psr_pkg::PAD_MASK;
      default: ex = 16'h0000;
    endcase
  endfunction : ex

  // alert only from bits allowed to raise it
  function automatic logic ea();
    logic a;
    a = |{mb, mo, mn[7], mc};
    foreach (m[k, c]) a |= |m[k][c];
    return a;
  endfunction : ea

  // one request on the host user side, answer left in r
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    reqValid = 1'b1;
    reqWrite = w;
    reqCode = c;
    reqData = d;
    @(negedge ref_clk);
    reqValid = 1'b0;
    n = 0;
    while (doneValid !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    r = doneData;
    @(negedge ref_clk);
  endtask : xfer

  // write plus its effect on the model
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    int k;
    xfer(1'b1, c, d);
    k = c == psr_pkg::CMD_VOUT ? 0 : c == psr_pkg::CMD_IOUT ? 1 :
      c == psr_pkg::CMD_TEMP ? 2 : c == psr_pkg::CMD_VENDOR ? 3 : 4;
    if (k < 4) m[k][pg] &= ~d[7:0];
    if (c == psr_pkg::CMD_PAGE) pg = d[0];
    if (c == psr_pkg::CMD_CLEAR) zero();
    if (c == psr_pkg::CMD_INPUT) mn &= ~(d[7:0] & psr_pkg::INP_W1C_MASK);
    if (c == psr_pkg::CMD_CML) mc &= ~d[7:0];
    if (c == psr_pkg::CMD_PADS) mc[6] = 1'b1;
    if (c == psr_pkg::CMD_SUM_BYTE) mb[pg] &= ~d[7];
    if (c == psr_pkg::CMD_SUM_BYTE) mo[pg] &= ~d[0];
    absorb();
  endtask : wr

  task automatic setRaw;
    rawIn = raw;
    repeat (40) @(negedge ref_clk);
    absorb();
  endtask : setRaw

  // every status register of both pages, then the alert level
  task automatic rdPages;
    for (int p = 0; p < 2; p++) begin
      wr(psr_pkg::CMD_PAGE, 16'(p));
      foreach (codes[i]) begin
        xfer(1'b0, codes[i], 16'h0000);
        chk(r, ex(codes[i], pg));
      end
    end
    chk({15'h0000, alert}, {15'h0000, ea()});
  endtask : rdPages

  // main sequence
  initial begin
    void'($urandom(32'h14dd));
    zero();
    raw.outOn = 2'b11;
    raw.pwrGood = 2'b11;
    rawIn = raw;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    setRaw();
    rdPages();
    for (int i = 0; i < 3; i++) begin
      rnd = {$urandom, $urandom, $urandom, $urandom};
      raw = rnd[103:0];
      setRaw();
      rdPages();
      raw = '0;
      setRaw();
      wr(psr_pkg::CMD_PAGE, 16'(i % 2));
      foreach (w1c[k]) wr(w1c[k], 16'($urandom));
      wr(psr_pkg::CMD_PADS, 16'hffff);
      xfer(1'b0, 8'h55, 16'h0000);
      chk(r, 16'h0000);
      mc[7] = 1'b1;
      rdPages();
    end
    raw.vout[1] = 8'h80;
    setRaw();
    wr(psr_pkg::CMD_CLEAR, 16'h0000);
    rdPages();
    raw = '0;
    raw.outOn = 2'b11;
    raw.pwrGood = 2'b11;
    setRaw();
    wr(psr_pkg::CMD_CLEAR, 16'h0000);
    rdPages();
    print_verdict();
  end
endmodule : pmbus_status_reporting_test
